// *** rtl/ocm_config_map.sv ***
// OTP configuration map of a USB to UART bridge: storage, locks, effective
// settings, descriptor fields and live pin functions.
// Assumes a single clock, inputs synchronous to it, one access per request.
//
// Behaviour
// - Override bit 4 picks stored latency threshold, else built-in default.
// - Override bits 3,2,1 pick stored masks, directions, pin modes.
// - Override bit 0 picks the stored flow byte over the default.
// - Half duplex drops receive data while the UART transmits.
// - Flow 000 none, 001 hardware with chosen pair, 010 software.
// - Flow 011 receive after match, 100 both gated, others reserved.
// - Mode bit 7 turns pin 6 into a clock output.
// - Pin 7 select: gpio, enable while sending, enable during match.
// - Mode bit 4 gives pin 7 the select field; pin 5 must differ.
// - Pin mode 000 gpio, 001 pins 4/5 rts-cts, 010 pins 2/3 dtr-dsr.
// - Pin mode 011 drives pin 5 while sending, 100 after match.
// - High mode bits 1,0 default set and enable activity toggles.
// - Ten direction bits: 0 input, 1 output.
// - Unmasked input changes, receive line included, raise an interrupt.
// - Threshold is 24 bits from three bytes, low byte first.
// - Vendor and product codes join low and high bytes.
// - Max power byte reported in 2 mA units, valid 0x01 to 0xFA.
// - Remote wake goes to D5 only when advertise bit is set.
// - Power mode 00 bus, 01 and 10 self, 11 invalid.
// - Flush bits 4..1 empty FIFOs on port open and close.
// - Locked fields refuse programming; host fills field before locking.
// - Lockable fields act only after locking; blank reads zero.
`timescale 1ns/10ps
`default_nettype none
`include "ocm_regs.svh"

module ocm_config_map import ocm_pkg::*; #(
  // Arbitrary built-in identity and release values
  parameter logic [15:0] DEFAULT_VID = 16'h1234,
  parameter logic [15:0] DEFAULT_PID = 16'h5678,
  parameter logic [15:0] DEFAULT_RELEASE = 16'h0100
) (
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic field_commit_bit_req_in,
  input wire logic field_commit_bit_write_in,
  input wire logic [7:0] field_commit_bit_addr_in,
  input wire logic [7:0] field_commit_bit_wdata_in,
  output logic field_commit_bit_ack_out,
  output logic field_commit_bit_refused_out,
  output logic [7:0] field_commit_bit_rdata_out,
  input wire logic tx_active_in,
  input wire logic addr_match_in,
  input wire logic [9:0] gpio_in,
  input wire logic rx_line_in,
  output logic irq_packet_out,
  output ocm_func_type func_out,
  output ocm_desc_type desc_out,
  output logic [9:0] gpio_dir_out,
  output logic [23:0] thresh_out,
  output logic pin7_xcvr_enable,
  output logic pin5_handshake_out,
  output logic rx_discard_out,
  output logic rx_accept_out,
  output logic tx_permit_out
);

  typedef struct packed {
    logic [`OCM_OTP_BYTES-1:0][7:0] otp;
    logic ack;
    logic refused;
    logic [7:0] rdata;
    logic primed;
    logic [10:0] in_prev;
    logic irq;
    ocm_func_type func;
    ocm_desc_type desc;
    logic [9:0] dir;
    logic [23:0] thresh;
    logic pin7;
    logic pin5;
    logic rx_discard;
    logic rx_accept;
    logic tx_permit;
  } ocm_state_type;

  ocm_state_type state;
  ocm_state_type next_state;

  logic [7:0] ovr;
  logic [7:0] lock_hi;
  logic [7:0] eff_flow;
  logic [7:0] eff_mode_lo;
  logic [7:0] eff_mode_hi;
  logic [9:0] eff_dir;
  logic [10:0] eff_mask;
  logic [23:0] eff_thresh;
  logic [7:0] pwr_raw;
  logic [7:0] attr_raw;
  logic [7:0] flush_raw;
  logic [10:0] in_now;
  logic [10:0] in_change;
  logic in_range;
  logic [4:0] idx;
  logic field_locked;
  ocm_func_type dec;

  // Stored bytes that steer the effective settings
  assign ovr = state.otp[`OCM_IDX(`OCM_ADDR_OVERRIDE)];
  assign lock_hi = state.otp[`OCM_IDX(`OCM_ADDR_LOCK_HI)];
  assign pwr_raw = state.otp[`OCM_IDX(`OCM_ADDR_MAXPWR)];
  assign attr_raw = state.otp[`OCM_IDX(`OCM_ADDR_ATTR)];
  assign flush_raw = state.otp[`OCM_IDX(`OCM_ADDR_FLUSH)];

  assign eff_flow = ovr[`OCM_OVR_FLOW] ?
    state.otp[`OCM_IDX(`OCM_ADDR_FLOW)] : `OCM_DFLT_FLOW;
  assign eff_mode_lo = ovr[`OCM_OVR_GMODE] ?
    state.otp[`OCM_IDX(`OCM_ADDR_MODE_LO)] : `OCM_DFLT_MODE_LO;
  assign eff_mode_hi = ovr[`OCM_OVR_GMODE] ?
    state.otp[`OCM_IDX(`OCM_ADDR_MODE_HI)] : `OCM_DFLT_MODE_HI;
  assign eff_dir = ovr[`OCM_OVR_GDIR] ?
    {state.otp[`OCM_IDX(`OCM_ADDR_DIR_HI)][1:0],
     state.otp[`OCM_IDX(`OCM_ADDR_DIR_LO)]} : `OCM_DFLT_DIR;
  // mask override, receive line on top
  assign eff_mask = ovr[`OCM_OVR_GMASK] ?
    {state.otp[`OCM_IDX(`OCM_ADDR_MASK_HI)][`OCM_MASKH_RX:0],
     state.otp[`OCM_IDX(`OCM_ADDR_MASK_LO)]} : `OCM_DFLT_MASK;
  assign eff_thresh = ovr[`OCM_OVR_THRESH] ?
    {state.otp[`OCM_IDX(`OCM_ADDR_THR2)],
     state.otp[`OCM_IDX(`OCM_ADDR_THR1)],
     state.otp[`OCM_IDX(`OCM_ADDR_THR0)]} : `OCM_DFLT_THRESH;

  // Pin and flow decode of the effective bytes
  ocm_decode u_decode (
    .flow_in(eff_flow),
    .mode_lo_in(eff_mode_lo),
    .mode_hi_in(eff_mode_hi),
    .func_out(dec)
  );

  // Per-input change detection
  assign in_now = {rx_line_in, gpio_in};
  genvar gi;
  generate
    for (gi = 0; gi < 11; gi++) begin : g_change
      assign in_change[gi] = state.primed &&
        (in_now[gi] != state.in_prev[gi]) && !eff_mask[gi];
    end
  endgenerate

  // Address decode of the programming port
  assign in_range = (field_commit_bit_addr_in >= `OCM_ADDR_OVERRIDE) &&
    (field_commit_bit_addr_in <= `OCM_ADDR_LOCK_HI);
  assign idx = in_range ? 5'(field_commit_bit_addr_in - `OCM_ADDR_OVERRIDE) : 5'h0_0;

  // Lock lookup for the addressed field
  always_comb begin
    field_locked = 1'b0;
    unique case (field_commit_bit_addr_in)
      `OCM_ADDR_VID_LO, `OCM_ADDR_VID_HI:
        field_locked = lock_hi[`OCM_LOCK_VID];
      `OCM_ADDR_PID_LO, `OCM_ADDR_PID_HI:
        field_locked = lock_hi[`OCM_LOCK_PID];
      `OCM_ADDR_MAXPWR: field_locked = lock_hi[`OCM_LOCK_PWR];
      `OCM_ADDR_ATTR: field_locked = lock_hi[`OCM_LOCK_ATTR];
      `OCM_ADDR_REL_MAJ, `OCM_ADDR_REL_MIN:
        field_locked = lock_hi[`OCM_LOCK_REL];
      `OCM_ADDR_FLUSH: field_locked = lock_hi[`OCM_LOCK_FLUSH];
      default: field_locked = 1'b0;
    endcase
  end

  // Next state of storage, descriptors and live pins
  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    next_state.refused = 1'b0;
    if (field_commit_bit_req_in) begin
      next_state.ack = 1'b1;
      // blank and unmapped locations read zero
      next_state.rdata = in_range ? state.otp[idx] : 8'h00;
      if (field_commit_bit_write_in) begin
        if (!in_range || field_locked) begin
          next_state.refused = 1'b1;
        end else begin
          // Writes only take fuse bits from 0 to 1; reset clears them all
          next_state.otp[idx] = state.otp[idx] | field_commit_bit_wdata_in;
        end
      end
    end
    next_state.func = dec;
    next_state.dir = eff_dir;
    next_state.thresh = eff_thresh;
    next_state.desc.vid = lock_hi[`OCM_LOCK_VID] ?
      {state.otp[`OCM_IDX(`OCM_ADDR_VID_HI)],
       state.otp[`OCM_IDX(`OCM_ADDR_VID_LO)]} : DEFAULT_VID;
    next_state.desc.pid = lock_hi[`OCM_LOCK_PID] ?
      {state.otp[`OCM_IDX(`OCM_ADDR_PID_HI)],
       state.otp[`OCM_IDX(`OCM_ADDR_PID_LO)]} : DEFAULT_PID;
    // power budget within its valid range
    next_state.desc.max_power = (lock_hi[`OCM_LOCK_PWR] &&
      pwr_raw >= `OCM_PWR_MIN && pwr_raw <= `OCM_PWR_MAX) ?
      pwr_raw : `OCM_DFLT_MAXPWR;
    next_state.desc.attributes = `OCM_ATTR_BASE;
    if (lock_hi[`OCM_LOCK_ATTR]) begin
      next_state.desc.attributes[`OCM_ATTR_SELF] =
        attr_raw[1:0] == 2'h1 || attr_raw[1:0] == 2'h2;
      next_state.desc.attributes[`OCM_ATTR_WAKE] =
        attr_raw[`OCM_ATTR_RWV] && attr_raw[`OCM_ATTR_RWE];
    end
    next_state.desc.release_bcd = lock_hi[`OCM_LOCK_REL] ?
      {state.otp[`OCM_IDX(`OCM_ADDR_REL_MAJ)],
       state.otp[`OCM_IDX(`OCM_ADDR_REL_MIN)]} : DEFAULT_RELEASE;
    next_state.desc.flush = lock_hi[`OCM_LOCK_FLUSH] ? flush_raw[4:1] : 4'h0;
    next_state.pin7 = (dec.pin7_fn == PIN7_XCVR_SEND && tx_active_in) ||
      (dec.pin7_fn == PIN7_XCVR_MATCH && addr_match_in);
    next_state.pin5 = (dec.pin5_fn == PIN5_XCVR_SEND && tx_active_in) ||
      (dec.pin5_fn == PIN5_XCVR_MATCH && addr_match_in);
    next_state.rx_discard = dec.half_duplex && tx_active_in;
    next_state.rx_accept = !(dec.half_duplex && tx_active_in) &&
      ((dec.flow_mode != FLOW_MULTI_RX && dec.flow_mode != FLOW_MULTI_BOTH)
       || addr_match_in);
    next_state.tx_permit = dec.flow_mode != FLOW_MULTI_BOTH || addr_match_in;
    next_state.in_prev = in_now;
    next_state.primed = 1'b1;
    next_state.irq = |in_change;
  end

  // State register
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state
  assign field_commit_bit_ack_out = state.ack;
  assign field_commit_bit_refused_out = state.refused;
  assign field_commit_bit_rdata_out = state.rdata;
  assign irq_packet_out = state.irq;
  assign func_out = state.func;
  assign desc_out = state.desc;
  assign gpio_dir_out = state.dir;
  assign thresh_out = state.thresh;
  assign pin7_xcvr_enable = state.pin7;
  assign pin5_handshake_out = state.pin5;
  assign rx_discard_out = state.rx_discard;
  assign rx_accept_out = state.rx_accept;
  assign tx_permit_out = state.tx_permit;

  // Checks on the live outputs and storage
  AST_THRESH_DEFAULT:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !ovr[`OCM_OVR_THRESH] |=> thresh_out == `OCM_DFLT_THRESH)
    else $error("threshold not default with override clear");
  AST_FLOW_DEFAULT:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !ovr[`OCM_OVR_FLOW] |=> func_out.flow_mode == FLOW_NONE &&
      !func_out.half_duplex)
    else $error("flow settings not default with override clear");
  AST_HALF_DUPLEX:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (func_out.half_duplex && tx_active_in) |=> rx_discard_out &&
      !rx_accept_out)
    else $error("receive not dropped while sending in half duplex");
  AST_TX_GATE:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (dec.flow_mode == FLOW_MULTI_BOTH && !addr_match_in) |=>
      !tx_permit_out)
    else $error("transmit permitted without match");
  AST_PIN7_SEND:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (dec.pin7_fn == PIN7_XCVR_SEND) |=>
      pin7_xcvr_enable == $past(tx_active_in))
    else $error("pin 7 enable does not follow transmit");
  AST_PIN7_GPIO:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !eff_mode_lo[`OCM_MODE_RSPIN] |=> !pin7_xcvr_enable)
    else $error("pin 7 driven while its select bit is clear");
  AST_IRQ_MASKED:
    assert property (@(posedge clock_in) disable iff (rst_in)
      ((in_now ^ state.in_prev) & ~eff_mask) == 11'h000 |=> !irq_packet_out)
    else $error("interrupt raised without an unmasked input change");
  AST_POWER_RANGE:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !$past(rst_in) |-> desc_out.max_power >= `OCM_PWR_MIN &&
      desc_out.max_power <= `OCM_PWR_MAX)
    else $error("reported max power out of range");
  AST_LOCK_REFUSE:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (field_commit_bit_req_in && field_commit_bit_write_in && in_range && field_locked) |=>
      field_commit_bit_refused_out && state.otp == $past(state.otp))
    else $error("locked field accepted a write");
  AST_FUSE_KEEP:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (($past(state.otp) & ~state.otp) == '0))
    else $error("programmed fuse bit cleared");
  AST_IRQ_RAISE:
    assert property (@(posedge clock_in) disable iff (rst_in)
      state.primed && ((in_now ^ state.in_prev) & ~eff_mask) != 11'h000 |=>
      irq_packet_out)
    else $error("unmasked input change raised no interrupt");
  AST_ACK_IDLE:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !field_commit_bit_req_in |=> !field_commit_bit_ack_out && !field_commit_bit_refused_out)
    else $error("answer given without a request");
  AST_DIR_DEFAULT:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !ovr[`OCM_OVR_GDIR] |=> gpio_dir_out == `OCM_DFLT_DIR)
    else $error("direction not default with override clear");
  AST_PIN5_SEND:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (dec.pin5_fn == PIN5_XCVR_SEND) |=>
      pin5_handshake_out == $past(tx_active_in))
    else $error("pin 5 enable does not follow transmit");
  AST_PIN7_MATCH:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (dec.pin7_fn == PIN7_XCVR_MATCH) |=>
      pin7_xcvr_enable == $past(addr_match_in))
    else $error("pin 7 enable does not follow address match");
  AST_RX_GATE:
    assert property (@(posedge clock_in) disable iff (rst_in)
      (dec.flow_mode == FLOW_MULTI_RX && !addr_match_in) |=> !rx_accept_out)
    else $error("receive accepted without match");
  AST_VID_DEFAULT:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !lock_hi[`OCM_LOCK_VID] |=> desc_out.vid == DEFAULT_VID)
    else $error("vendor code used before its lock bit");
  AST_WAKE_HIDDEN:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !attr_raw[`OCM_ATTR_RWV] |=> !desc_out.attributes[`OCM_ATTR_WAKE])
    else $error("remote wake advertised without valid bit");
  AST_TOGGLE_DEFAULT:
    assert property (@(posedge clock_in) disable iff (rst_in)
      !ovr[`OCM_OVR_GMODE] |=> func_out.pin8_tx_toggle &&
      func_out.pin9_rx_toggle)
    else $error("activity toggles off with mode override clear");

endmodule : ocm_config_map
`default_nettype wire

// *** common/ocm_regs.svh ***
// Offsets, field positions, reset values and defaults of the OTP config map.
// Assumes inclusion by bare name from the two design files.
`ifndef OCM_REGS_SVH
`define OCM_REGS_SVH

// Byte offsets of the stored locations
`define OCM_ADDR_OVERRIDE 8'h07
`define OCM_ADDR_FLOW 8'h08
`define OCM_ADDR_MODE_LO 8'h09
`define OCM_ADDR_MODE_HI 8'h0A
`define OCM_ADDR_DIR_LO 8'h0B
`define OCM_ADDR_DIR_HI 8'h0C
`define OCM_ADDR_MASK_LO 8'h0D
`define OCM_ADDR_MASK_HI 8'h0E
`define OCM_ADDR_THR0 8'h0F
`define OCM_ADDR_THR1 8'h10
`define OCM_ADDR_THR2 8'h11
`define OCM_ADDR_VID_LO 8'h12
`define OCM_ADDR_VID_HI 8'h13
`define OCM_ADDR_PID_LO 8'h14
`define OCM_ADDR_PID_HI 8'h15
`define OCM_ADDR_MAXPWR 8'h16
`define OCM_ADDR_ATTR 8'h17
`define OCM_ADDR_REL_MAJ 8'h18
`define OCM_ADDR_REL_MIN 8'h19
`define OCM_ADDR_FLUSH 8'h1A
`define OCM_ADDR_LOCK_LO 8'h1B
`define OCM_ADDR_LOCK_HI 8'h1C
`define OCM_OTP_BYTES 22
`define OCM_IDX(a) ((a) - `OCM_ADDR_OVERRIDE)

// Override select bits
`define OCM_OVR_FLOW 0
`define OCM_OVR_GMODE 1
`define OCM_OVR_GDIR 2
`define OCM_OVR_GMASK 3
`define OCM_OVR_THRESH 4

// Flow and mode fields
`define OCM_FLOW_HDX 3
`define OCM_MODE_CLK 7
`define OCM_MODE_RSSEL_HI 6
`define OCM_MODE_RSSEL_LO 5
`define OCM_MODE_RSPIN 4
`define OCM_MODEH_RXTOG 1
`define OCM_MODEH_TXTOG 0
`define OCM_MASKH_RX 2

// Descriptor attribute fields and lock bits of the high lock byte
`define OCM_ATTR_RWE 3
`define OCM_ATTR_RWV 2
`define OCM_LOCK_VID 0
`define OCM_LOCK_PID 1
`define OCM_LOCK_PWR 2
`define OCM_LOCK_ATTR 3
`define OCM_LOCK_REL 4
`define OCM_LOCK_FLUSH 5

// Built-in defaults
`define OCM_DFLT_FLOW 8'h00
`define OCM_DFLT_MODE_LO 8'h00
`define OCM_DFLT_MODE_HI 8'h03
`define OCM_DFLT_DIR 10'h000
`define OCM_DFLT_MASK 11'h000
`define OCM_DFLT_THRESH 24'h00_0000
`define OCM_DFLT_MAXPWR 8'h32
`define OCM_PWR_MIN 8'h01
`define OCM_PWR_MAX 8'hFA
`define OCM_ATTR_BASE 8'h80
`define OCM_ATTR_SELF 6
`define OCM_ATTR_WAKE 5

`endif

// *** common/ocm_pkg.sv ***
// Types shared by the OTP config map and its decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package ocm_pkg;

  // Effective UART flow behaviour
  typedef enum logic [2:0] {
    FLOW_NONE,
    FLOW_HARDWARE,
    FLOW_SOFTWARE,
    FLOW_MULTI_RX,
    FLOW_MULTI_BOTH
  } ocm_flow_mode_type;

  // Function of pin 5
  typedef enum logic [1:0] {
    PIN5_GPIO,
    PIN5_HANDSHAKE,
    PIN5_XCVR_SEND,
    PIN5_XCVR_MATCH
  } ocm_pin5_fn_type;

  // Function of pin 7
  typedef enum logic [1:0] {
    PIN7_GPIO,
    PIN7_XCVR_SEND,
    PIN7_XCVR_MATCH
  } ocm_pin7_fn_type;

  // Decoded static pin and UART settings
  typedef struct packed {
    logic half_duplex;
    ocm_flow_mode_type flow_mode;
    logic rts_cts_auto;
    logic dtr_dsr_auto;
    ocm_pin5_fn_type pin5_fn;
    ocm_pin7_fn_type pin7_fn;
    logic pin6_clock;
    logic pin8_tx_toggle;
    logic pin9_rx_toggle;
  } ocm_func_type;

  // Descriptor fields reported on enumeration
  typedef struct packed {
    logic [15:0] vid;
    logic [15:0] pid;
    logic [7:0] max_power;
    logic [7:0] attributes;
    logic [15:0] release_bcd;
    logic [3:0] flush;
  } ocm_desc_type;

endpackage : ocm_pkg

// *** rtl/ocm_decode.sv ***
// Decoder from the effective flow and mode bytes to pin functions.
// Assumes the caller has already chosen between defaults and stored bytes.
`timescale 1ns/10ps
`default_nettype none
`include "ocm_regs.svh"

module ocm_decode import ocm_pkg::*; (
  input wire logic [7:0] flow_in,
  input wire logic [7:0] mode_lo_in,
  input wire logic [7:0] mode_hi_in,
  output ocm_func_type func_out
);

  // Field decode, reserved codes fall back to code zero
  always_comb begin
    func_out = '0;
    func_out.half_duplex = flow_in[`OCM_FLOW_HDX];
    unique case (flow_in[2:0])
      3'h1: func_out.flow_mode = FLOW_HARDWARE;
      3'h2: func_out.flow_mode = FLOW_SOFTWARE;
      3'h3: func_out.flow_mode = FLOW_MULTI_RX;
      3'h4: func_out.flow_mode = FLOW_MULTI_BOTH;
      default: func_out.flow_mode = FLOW_NONE;
    endcase
    unique case (mode_lo_in[2:0])
      3'h1: func_out.pin5_fn = PIN5_HANDSHAKE;
      3'h3: func_out.pin5_fn = PIN5_XCVR_SEND;
      3'h4: func_out.pin5_fn = PIN5_XCVR_MATCH;
      default: func_out.pin5_fn = PIN5_GPIO;
    endcase
    func_out.rts_cts_auto = (flow_in[2:0] == 3'h1) &&
      (mode_lo_in[2:0] == 3'h1);
    func_out.dtr_dsr_auto = (flow_in[2:0] == 3'h1) &&
      (mode_lo_in[2:0] == 3'h2);
    if (mode_lo_in[`OCM_MODE_RSPIN]) begin
      unique case (mode_lo_in[`OCM_MODE_RSSEL_HI:`OCM_MODE_RSSEL_LO])
        2'h1: func_out.pin7_fn = PIN7_XCVR_SEND;
        2'h2: func_out.pin7_fn = PIN7_XCVR_MATCH;
        default: func_out.pin7_fn = PIN7_GPIO;
      endcase
    end
    func_out.pin6_clock = mode_lo_in[`OCM_MODE_CLK];
    func_out.pin8_tx_toggle = mode_hi_in[`OCM_MODEH_TXTOG];
    func_out.pin9_rx_toggle = mode_hi_in[`OCM_MODEH_RXTOG];
  end

endmodule : ocm_decode
`default_nettype wire

// *** testbench/ocm_host_model.sv ***
// Host model that programs and reads the config map one byte at a time.
// Assumes the map acks each request on the same clock edge that takes it.
`timescale 1ns/10ps
`default_nettype none

module ocm_host_model (
  input wire logic clock_in,
  input wire logic ack_in,
  input wire logic refused_in,
  input wire logic [7:0] rdata_in,
  output logic req_out,
  output logic write_out,
  output logic [7:0] addr_out,
  output logic [7:0] wdata_out
);
  logic [7:0] last_rdata;
  logic last_refused;
  logic last_ack;

  // Idle request lines
  initial begin
    req_out = 1'b0;
    write_out = 1'b0;
    addr_out = 8'h5A;
    wdata_out = 8'hA5;
  end

  // One access: raise after an edge, collect the answer after the taking edge
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge clock_in);
    #1;
    req_out = 1'b1;
    write_out = wr;
    addr_out = a;
    wdata_out = d;
    @(posedge clock_in);
    #1;
    last_ack = ack_in;
    last_refused = refused_in;
    last_rdata = rdata_in;
    // Released address and data lines show the inverse, not a stale value
    req_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : xfer
endmodule : ocm_host_model

`default_nettype wire

// *** testbench/tb_otp_usb_uart_config_map.sv ***
// Self-checking bench of the OTP config map with a host model.
// Assumes the design acks every access on the clock edge that takes it.
`timescale 1ns/10ps
`default_nettype none

`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_otp_usb_uart_config_map import ocm_pkg::*;;
  localparam logic [15:0] VID_DEF = 16'h2468; // Arbitrary value
  localparam logic [15:0] PID_DEF = 16'h1357; // Arbitrary value
  localparam logic [15:0] REL_DEF = 16'h0102;
  typedef struct {
    logic [7:0] flow;
    logic [7:0] mode;
    logic [1:0] lv;
    ocm_flow_mode_type fm;
    ocm_pin7_fn_type p7fn;
    logic [8:0] exp;
  } ocm_row_type;
  logic clock_in, rst_in, req, wr, ack, refused, tx, match, rx_line, irq;
  logic p7, p5, disc, acc, txp;
  logic [7:0] addr, wdata, rdata;
  logic [9:0] gpio, dir;
  logic [23:0] thresh;
  logic [15:0] at [4] = '{16'h09C0, 16'h0EE0, 16'h0380, 16'h0CA0};
  ocm_func_type func;
  ocm_desc_type desc;
  logic [8:0] pins;
  int miscompares = 0;
  int samples_checked = 0;
  // pin 5 kept apart from pin 7 in the last row
  ocm_row_type rows [19] = '{
    '{8'h00, 8'h00, 2'h2, FLOW_NONE, PIN7_GPIO, 9'h003},
    '{8'h01, 8'h01, 2'h0, FLOW_HARDWARE, PIN7_GPIO, 9'h043},
    '{8'h01, 8'h02, 2'h0, FLOW_HARDWARE, PIN7_GPIO, 9'h023},
    '{8'h02, 8'h00, 2'h0, FLOW_SOFTWARE, PIN7_GPIO, 9'h003},
    '{8'h03, 8'h03, 2'h2, FLOW_MULTI_RX, PIN7_GPIO, 9'h009},
    '{8'h03, 8'h03, 2'h1, FLOW_MULTI_RX, PIN7_GPIO, 9'h003},
    '{8'h04, 8'h04, 2'h0, FLOW_MULTI_BOTH, PIN7_GPIO, 9'h000},
    '{8'h04, 8'h04, 2'h1, FLOW_MULTI_BOTH, PIN7_GPIO, 9'h00B},
    '{8'h05, 8'h05, 2'h3, FLOW_NONE, PIN7_GPIO, 9'h003},
    '{8'h06, 8'h06, 2'h3, FLOW_NONE, PIN7_GPIO, 9'h003},
    '{8'h07, 8'h07, 2'h3, FLOW_NONE, PIN7_GPIO, 9'h003},
    '{8'h08, 8'h00, 2'h2, FLOW_NONE, PIN7_GPIO, 9'h105},
    '{8'h08, 8'h00, 2'h0, FLOW_NONE, PIN7_GPIO, 9'h103},
    '{8'h00, 8'h30, 2'h2, FLOW_NONE, PIN7_XCVR_SEND, 9'h013},
    '{8'h00, 8'h50, 2'h1, FLOW_NONE, PIN7_XCVR_MATCH, 9'h013},
    '{8'h00, 8'h70, 2'h3, FLOW_NONE, PIN7_GPIO, 9'h003},
    '{8'h00, 8'h20, 2'h2, FLOW_NONE, PIN7_GPIO, 9'h003},
    '{8'h00, 8'h80, 2'h0, FLOW_NONE, PIN7_GPIO, 9'h083},
    '{8'h00, 8'h53, 2'h2, FLOW_NONE, PIN7_XCVR_MATCH, 9'h00B}};

  // Decoded pin and gate outputs gathered for the row compare
  assign pins = {func.half_duplex, func.pin6_clock, func.rts_cts_auto,
    func.dtr_dsr_auto, p7, p5, disc, acc, txp};

  // Free-running 100 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #5 clock_in = ~clock_in;
  end

  ocm_config_map #(.DEFAULT_VID(VID_DEF), .DEFAULT_PID(PID_DEF),
    .DEFAULT_RELEASE(REL_DEF)) ocm_config_map_inst (
    .clock_in(clock_in), .rst_in(rst_in), .field_commit_bit_req_in(req),
    .field_commit_bit_write_in(wr), .field_commit_bit_addr_in(addr), .field_commit_bit_wdata_in(wdata),
    .field_commit_bit_ack_out(ack), .field_commit_bit_refused_out(refused), .field_commit_bit_rdata_out(rdata),
    .tx_active_in(tx), .addr_match_in(match), .gpio_in(gpio),
    .rx_line_in(rx_line), .irq_packet_out(irq), .func_out(func),
    .desc_out(desc), .gpio_dir_out(dir), .thresh_out(thresh),
    .pin7_xcvr_enable(p7), .pin5_handshake_out(p5), .rx_discard_out(disc),
    .rx_accept_out(acc), .tx_permit_out(txp));

  ocm_host_model ocm_host_model_inst (
    .clock_in(clock_in), .ack_in(ack), .refused_in(refused),
    .rdata_in(rdata), .req_out(req), .write_out(wr), .addr_out(addr),
    .wdata_out(wdata));

  // Bus access helpers; every access must be acked
  task automatic acc_b(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
    ocm_host_model_inst.xfer(w, a, d);
    `CHK("ack", 1'b1, ocm_host_model_inst.last_ack)
  endtask : acc_b

  task automatic wr_list(input logic [15:0] q [$]);
    foreach (q[i]) begin
      acc_b(1'b1, q[i][15:8], q[i][7:0]);
    end
  endtask : wr_list

  task automatic tick();
    @(posedge clock_in);
    #1;
  endtask : tick

  // Reset held for four clocks
  task automatic do_reset();
    tick();
    rst_in = 1'b1;
    repeat (4) @(posedge clock_in);
    #1 rst_in = 1'b0;
    tick();
  endtask : do_reset

  // Flip inputs and watch for a one-cycle interrupt pulse
  task automatic poke(input logic [10:0] flip, input logic e);
    tick();
    {rx_line, gpio} = {rx_line, gpio} ^ flip;
    tick();
    `CHK("irq", e, irq)
    tick();
    `CHK("irq end", 1'b0, irq)
  endtask : poke

  task automatic tally_and_finish();
    $display("Checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog well beyond the expected run of about 400 cycles
  initial begin
    #100000;
    miscompares++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    rst_in = 1'b1;
    {tx, match, rx_line, gpio} = 13'h0000;
    foreach (rows[i]) begin
      do_reset();
      {tx, match} = rows[i].lv;
      wr_list('{16'h0703, {8'h08, rows[i].flow}, {8'h09, rows[i].mode}});
      tick();
      `CHK("flow mode", rows[i].fm, func.flow_mode)
      `CHK("pin7 fn", rows[i].p7fn, func.pin7_fn)
      `CHK("pins", rows[i].exp, pins)
    end
    $display("Test rows done");
    do_reset();
    `CHK("vid", VID_DEF, desc.vid)
    `CHK("rel", REL_DEF, desc.release_bcd)
    `CHK("power", 8'h32, desc.max_power)
    `CHK("attr", 8'h80, desc.attributes)
    `CHK("toggles", 2'h3, {func.pin9_rx_toggle, func.pin8_tx_toggle})
    acc_b(1'b0, 8'h12, 8'h00);
    `CHK("blank", 8'h00, ocm_host_model_inst.last_rdata)
    wr_list('{16'h0F11, 16'h1022, 16'h1133, 16'h0BA5, 16'h0C02, 16'h0A01});
    tick();
    `CHK("thresh off", 24'h00_0000, thresh)
    `CHK("dir off", 10'h000, dir)
    wr_list('{16'h0716});
    tick();
    `CHK("thresh on", 24'h33_2211, thresh)
    `CHK("dir on", 10'h2A5, dir)
    `CHK("toggles", 2'h1, {func.pin9_rx_toggle, func.pin8_tx_toggle})
    $display("Test overrides done");
    do_reset();
    // fill each field before locking it
    wr_list('{16'h1234, 16'h13AB, 16'h16FA, 16'h1802, 16'h1937, 16'h1A14});
    tick();
    `CHK("vid open", VID_DEF, desc.vid)
    wr_list('{16'h1C35});
    tick();
    `CHK("vid", 16'hAB34, desc.vid)
    `CHK("pid", PID_DEF, desc.pid)
    `CHK("power", 8'hFA, desc.max_power)
    `CHK("rel", 16'h0237, desc.release_bcd)
    `CHK("flush", 4'hA, desc.flush)
    acc_b(1'b1, 8'h12, 8'hFF);
    `CHK("locked", 1'b1, ocm_host_model_inst.last_refused)
    acc_b(1'b0, 8'h12, 8'h00);
    `CHK("kept", 8'h34, ocm_host_model_inst.last_rdata)
    acc_b(1'b1, 8'h14, 8'h01);
    `CHK("open", 1'b0, ocm_host_model_inst.last_refused)
    acc_b(1'b1, 8'h20, 8'h01);
    `CHK("unmapped", 1'b1, ocm_host_model_inst.last_refused)
    foreach (at[i]) begin
      do_reset();
      wr_list('{{8'h17, at[i][15:8]}, 16'h1C08});
      tick();
      `CHK("attr", at[i][7:0], desc.attributes)
    end
    $display("Test descriptor done");
    do_reset();
    poke(11'h008, 1'b1);
    poke(11'h400, 1'b1);
    wr_list('{16'h0708, 16'h0D08, 16'h0E04});
    poke(11'h008, 1'b0);
    poke(11'h400, 1'b0);
    poke(11'h010, 1'b1);
    $display("Test interrupt done");
    tick();
    rst_in = 1'b1;
    #2;
    `CHK("desc in reset", 68'h0, desc)
    tick();
    rst_in = 1'b0;
    tick();
    `CHK("vid again", VID_DEF, desc.vid)
    poke(11'h008, 1'b1);
    $display("Test mid reset done");
    tally_and_finish();
  end
endmodule : tb_otp_usb_uart_config_map

`default_nettype wire
